//--- logic/io_interrupt_indicator_unit.sv
/*
 Input-output indicator unit: test, clear, block and permit instructions,
 interrupt request toward the sequencer.
 Assumes the sequencer holds instr until done, and supplies indirect words.
*/
`include "io_ind_params.svh"
`timescale 1ns/1ps
`default_nettype none
module io_interrupt_indicator_unit (
  input wire logic mclk,
  input wire logic rst,
  input wire io_ind_pkg::instr_t instr,
  input wire io_ind_pkg::set_req_t set_req,
  output logic ind_req,
  input wire logic [25:0] ind_word,
  input wire logic ind_valid,
  input wire logic instr_end,
  output io_ind_pkg::result_t result,
  output logic busy,
  output logic irq_take,
  output logic save_counter,
  output logic [`CC_W-1:0] jump_addr,
  output logic interrupt_mode,
  output logic inhibit_flag,
  output logic suspended
);
  import io_ind_pkg::*;

  state_t state_q;
  logic [25:0] word_q;
  logic [`CC_W-1:0] cc_q;
  logic [1:0] cyc_q;
  logic [5:0] op;
  logic [3:0] ch;
  flags_t mask;
  flags_t rd_flags;
  logic any_set;
  logic clr_en;
  logic hold_q;
  logic hold_pend_q;
  logic known_op;

  function automatic logic [5:0] opcode_of(input logic [25:0] w);
    opcode_of = w[`BIT_OP_HI:`BIT_OP_LO];
  endfunction

  function automatic logic [3:0] channel_of(input logic [25:0] w);
    channel_of = w[`BIT_CH_HI:`BIT_CH_LO];
  endfunction

  assign op = opcode_of(word_q);
  assign ch = channel_of(word_q);
  // Positions 8..10 ignored
  assign mask = word_q[`BIT_MK_LO+`NUM_FLAGS-1:`BIT_MK_LO];
  assign clr_en = (state_q == ST_EXEC) && op == `OP_CLEAR;
  assign known_op = opcode_of(instr.word) == `OP_TEST ||
                    opcode_of(instr.word) == `OP_CLEAR ||
                    opcode_of(instr.word) == `OP_BLOCK ||
                    opcode_of(instr.word) == `OP_PERMIT;

  flag_store u_store (
    .mclk(mclk),
    .rst(rst),
    .rd_ch(ch),
    .rd_flags(rd_flags),
    .set_en(set_req.valid),
    .set_ch(set_req.channel),
    .set_flags(set_req.flags),
    .clr_en(clr_en),
    .clr_ch(ch),
    .clr_flags(mask),
    .any_set(any_set)
  );

  // Instruction sequencing
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      word_q <= '0;
      cc_q <= '0;
      cyc_q <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (instr.valid && known_op) begin
            word_q <= instr.word;
            cc_q <= instr.counter;
            cyc_q <= '0;
            if (instr.word[`BIT_IND] &&
                (opcode_of(instr.word) == `OP_TEST ||
                 opcode_of(instr.word) == `OP_CLEAR)) begin
              state_q <= ST_INDIRECT;
            end else begin
              state_q <= ST_EXEC;
            end
          end else if (irq_take) begin
            state_q <= ST_IRQ;
          end
        end
        ST_INDIRECT: begin
          if (ind_valid) begin
            word_q[`BIT_CH_HI:`BIT_MK_LO] <=
              ind_word[`BIT_CH_HI:`BIT_MK_LO];
            word_q[`BIT_IND] <= ind_word[`BIT_IND];
            state_q <= ind_word[`BIT_IND] ? ST_INDIRECT : ST_EXEC;
          end
        end
        ST_EXEC: begin
          cyc_q <= cyc_q + 2'd1;
          if (cyc_q + 2'd1 >= `OP_CYCLES - 2'd1) begin
            state_q <= ST_FINISH;
          end
        end
        ST_FINISH: state_q <= ST_IDLE;
        ST_IRQ: state_q <= ST_IDLE;
      endcase
    end
  end

  // Result and counter advance; test reads flags only
  always_ff @(posedge mclk) begin
    if (rst) begin
      result <= '0;
    end else begin
      result.done <= state_q == ST_FINISH;
      if (state_q == ST_FINISH) begin
        if (op == `OP_TEST && (rd_flags & mask) == '0) begin
          result.next_counter <= cc_q + `CC_TWO;
        end else begin
          result.next_counter <= cc_q + `CC_ONE;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= state_q != ST_IDLE;
    end
  end

  // Inhibit flag
  always_ff @(posedge mclk) begin
    if (rst) begin
      inhibit_flag <= 1'b0;
    end else if (state_q == ST_FINISH && op == `OP_BLOCK) begin
      inhibit_flag <= 1'b1;
    end else if (state_q == ST_FINISH && op == `OP_PERMIT) begin
      inhibit_flag <= 1'b0;
    end
  end

  // Hold after clear until next instruction ends
  always_ff @(posedge mclk) begin
    if (rst) begin
      hold_pend_q <= 1'b0;
      hold_q <= 1'b0;
    end else if (clr_en) begin
      hold_pend_q <= 1'b1;
      hold_q <= 1'b1;
    end else if (hold_pend_q && instr_end) begin
      hold_pend_q <= 1'b0;
    end else if (!hold_pend_q && instr_end) begin
      hold_q <= 1'b0;
    end
  end

  // Interrupt mode and suspension
  always_ff @(posedge mclk) begin
    if (rst) begin
      interrupt_mode <= 1'b0;
    end else if (clr_en) begin
      interrupt_mode <= 1'b0;
    end else if (irq_take) begin
      interrupt_mode <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      suspended <= 1'b0;
    end else begin
      suspended <= interrupt_mode && any_set;
    end
  end

  // Pending flags interrupt once permitted
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_take <= 1'b0;
      save_counter <= 1'b0;
      jump_addr <= '0;
    end else begin
      irq_take <= any_set && !inhibit_flag && !hold_q && !interrupt_mode &&
                  state_q == ST_IDLE && !irq_take;
      save_counter <= irq_take && !inhibit_flag;
      jump_addr <= `ENTRY_LOC;
    end
  end

  assign ind_req = state_q == ST_INDIRECT;
endmodule
`default_nettype wire

//--- logic/io_ind_params.svh
/*
 Constants for the input-output interrupt indicator unit.
 Assumes inclusion by bare name from logic files.
*/
`ifndef IO_IND_PARAMS_SVH
`define IO_IND_PARAMS_SVH
// Operation codes are octal: 64, 65, 62, 61 fit the 6-bit field
`define OP_TEST 6'h34
`define OP_CLEAR 6'h35
`define OP_BLOCK 6'h32
`define OP_PERMIT 6'h31
`define OP_CYCLES 2'h2
`define BIT_IND 25
`define BIT_IDX_HI 24
`define BIT_IDX_LO 21
`define BIT_OP_HI 20
`define BIT_OP_LO 15
`define BIT_CH_HI 14
`define BIT_CH_LO 11
`define BIT_MK_HI 10
`define BIT_MK_LO 1
`define CH_FIRST 4'h3
`define NUM_CH 16
`define NUM_FLAGS 7
`define ENTRY_LOC 15'h0020
`define CC_W 15
`define CC_ONE 15'h0001
`define CC_TWO 15'h0002
`endif

//--- logic/io_ind_pkg.sv
/*
 Types for the input-output interrupt indicator unit.
 Assumes the params header sits beside it.
*/
`include "io_ind_params.svh"
package io_ind_pkg;
  typedef logic [`NUM_FLAGS-1:0] flags_t;
  typedef struct packed {
    logic valid;
    logic [25:0] word;
    logic [`CC_W-1:0] counter;
  } instr_t;
  typedef struct packed {
    logic valid;
    logic [3:0] channel;
    flags_t flags;
  } set_req_t;
  typedef struct packed {
    logic done;
    logic [`CC_W-1:0] next_counter;
  } result_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_INDIRECT, ST_EXEC, ST_FINISH, ST_IRQ
  } state_t;
endpackage

//--- logic/flag_store.sv
/*
 Per-channel indicator memory with registered read data.
 Assumes one clock and synchronous active-high reset.
*/
`include "io_ind_params.svh"
`timescale 1ns/1ps
`default_nettype none
module flag_store (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] rd_ch,
  output logic [`NUM_FLAGS-1:0] rd_flags,
  input wire logic set_en,
  input wire logic [3:0] set_ch,
  input wire logic [`NUM_FLAGS-1:0] set_flags,
  input wire logic clr_en,
  input wire logic [3:0] clr_ch,
  input wire logic [`NUM_FLAGS-1:0] clr_flags,
  output logic any_set
);
  logic [`NUM_FLAGS-1:0] mem_q [`NUM_CH];
  logic any_d;

  // Set wins over clear; only addressed channel changes
  always_ff @(posedge mclk) begin
    for (int i = 0; i < `NUM_CH; i++) begin
      if (rst) begin
        mem_q[i] <= '0;
      end else begin
        if (clr_en && clr_ch == 4'(i)) begin
          mem_q[i] <= mem_q[i] & ~clr_flags;
        end
        if (set_en && set_ch == 4'(i) && set_ch >= `CH_FIRST) begin
          mem_q[i] <= (clr_en && clr_ch == 4'(i)) ?
            ((mem_q[i] & ~clr_flags) | set_flags) : (mem_q[i] | set_flags);
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_flags <= '0;
    end else begin
      rd_flags <= mem_q[rd_ch];
    end
  end

  always_comb begin
    any_d = 1'b0;
    for (int i = 0; i < `NUM_CH; i++) begin
      any_d = any_d | (|mem_q[i]);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      any_set <= 1'b0;
    end else begin
      any_set <= any_d;
    end
  end
endmodule
`default_nettype wire

//--- dv/io_ind_assertions.sv
/* Port checker for the indicator unit.
 Bound to the unit by the statement at the foot. */
`include "io_ind_params.svh"
`timescale 1ns/1ps
`default_nettype none
module io_ind_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire io_ind_pkg::instr_t instr,
  input wire io_ind_pkg::result_t result,
  input wire logic busy,
  input wire logic ind_req,
  input wire logic irq_take,
  input wire logic save_counter,
  input wire logic [`CC_W-1:0] jump_addr,
  input wire logic interrupt_mode,
  input wire logic inhibit_flag
);
  import io_ind_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic go;
  logic [5:0] op;
  assign op = instr.word[20:15];
  assign go = instr.valid && !busy && !result.done;
  done_timing_a: assert property ($rose(busy) && !$past(ind_req) &&
    !$past(irq_take, 2) |-> ##1 result.done)
    else $error("done not two cycles after start");
  done_pulse_a: assert property (result.done |=> !result.done)
    else $error("done held too long");
  block_sets_a: assert property (go && op == `OP_BLOCK |-> ##[3:4] inhibit_flag)
    else $error("inhibit not set");
  permit_clr_a: assert property (go && op == `OP_PERMIT |-> ##[3:4] !inhibit_flag)
    else $error("inhibit not cleared");
  clear_mode_a: assert property (go && op == `OP_CLEAR && !instr.word[25]
    |-> ##[3:4] !interrupt_mode)
    else $error("mode kept after clear");
  no_take_a: assert property (inhibit_flag && $past(inhibit_flag) |-> !irq_take)
    else $error("interrupt taken while inhibited");
  save_entry_a: assert property (irq_take |=> save_counter && jump_addr == `ENTRY_LOC)
    else $error("no save or wrong entry");
  skip_step_a: assert property (result.done && instr.valid |->
    result.next_counter == instr.counter + `CC_ONE ||
    result.next_counter == instr.counter + `CC_TWO)
    else $error("counter step wrong");
endmodule
bind io_interrupt_indicator_unit io_ind_checker chk (.mclk, .rst, .instr,
  .result, .busy, .ind_req, .irq_take, .save_counter, .jump_addr,
  .interrupt_mode, .inhibit_flag);
`default_nettype wire

//--- dv/sync_model.sv
/* Channel synchronizer stand-in raising indicator pulses.
 Called by the bench; shares the unit clock. */
`timescale 1ns/1ps
`default_nettype none
module sync_model (
  input wire logic mclk,
  output var io_ind_pkg::set_req_t set_req
);
  import io_ind_pkg::*;
  initial set_req = '{1'b0, 4'h0, 7'h00};
  task automatic raise(input logic [3:0] ch, input flags_t f);
    @(negedge mclk);
    set_req <= '{1'b1, ch, f};
    @(negedge mclk);
    set_req <= '{1'b0, ~ch, ~f};
  endtask
endmodule
`default_nettype wire

//--- dv/io_interrupt_indicator_unit_tb.sv
/* Bench for the indicator unit with a synchronizer model.
 Plays the sequencer: instructions, indirect words, ends. */
`include "io_ind_params.svh"
`timescale 1ns/1ps
`default_nettype none
module io_interrupt_indicator_unit_tb;
  import io_ind_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  instr_t instr = '0;
  set_req_t set_req;
  logic ind_req, ind_valid = 1'b0, instr_end = 1'b0;
  logic [25:0] ind_word = '0;
  result_t result;
  logic busy, irq_take, save_counter, mode, inhibit, susp;
  logic [`CC_W-1:0] jump_addr;
  int failures = 0;
  int checks = 0;
  int n;
  logic [4:0] c;
  always #5 mclk = ~mclk;
  sync_model syncs (.mclk, .set_req);
  io_interrupt_indicator_unit dut (.mclk, .rst, .instr, .set_req, .ind_req,
    .ind_word, .ind_valid, .instr_end, .result, .busy, .irq_take,
    .save_counter, .jump_addr, .interrupt_mode(mode),
    .inhibit_flag(inhibit), .suspended(susp));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One instruction; step 0 skips the counter compare
  task automatic run(input logic [5:0] op, input logic [3:0] ch,
      input flags_t mk, input logic ind, input int step);
    int k;
    logic [25:0] w;
    w = {ind, 4'h0, op, ch, 3'h0, mk, 1'b0};
    @(negedge mclk);
    instr <= '{1'b1, ind ? {w[25:15], ~w[14:0]} : w, 15'h0100};
    for (k = 0; k < 50 && !result.done; k++) begin
      @(negedge mclk);
      ind_valid <= ind_req;
      ind_word <= ind_req ? {1'b0, w[24:0]} : ~w;
    end
    check(result.done, 1'b1);
    if (step != 0) check(result.next_counter, 15'h0100 + step);
    instr.valid <= 1'b0;
    instr_end <= 1'b1;
    @(negedge mclk);
    instr_end <= 1'b0;
  endtask
  initial begin
    repeat (16) @(negedge mclk);
    rst <= 1'b0;
    run(`OP_TEST, 4'h3, 7'h7F, 1'b0, 2);
    run(`OP_BLOCK, 4'h0, 7'h00, 1'b0, 0);
    check(inhibit, 1'b1);
    syncs.raise(4'h5, 7'h22);
    run(`OP_TEST, 4'h5, 7'h20, 1'b0, 1);
    run(`OP_TEST, 4'h6, 7'h7F, 1'b0, 2);
    run(`OP_TEST, 4'h5, 7'h02, 1'b0, 1);
    check(mode, 1'b0);
    run(`OP_PERMIT, 4'h0, 7'h00, 1'b0, 0);
    for (n = 0; n < 20 && !mode; n++) @(negedge mclk);
    check(mode, 1'b1);
    @(negedge mclk);
    check(susp, 1'b1);
    run(`OP_CLEAR, 4'h5, 7'h7F, 1'b0, 0);
    check(mode, 1'b0);
    check(susp, 1'b0);
    run(`OP_CLEAR, 4'h5, 7'h7F, 1'b0, 0);
    run(`OP_TEST, 4'h5, 7'h7F, 1'b0, 2);
    for (c = 5'h03; c < 5'h10; c++) begin
      syncs.raise(c[3:0], 7'h40);
      run(`OP_TEST, c[3:0], 7'h40, 1'b0, 1);
      run(`OP_CLEAR, c[3:0], 7'h40, 1'b0, 0);
    end
    syncs.raise(4'hF, 7'h01);
    run(`OP_TEST, 4'hF, 7'h01, 1'b1, 1);
    run(`OP_CLEAR, 4'hF, 7'h01, 1'b1, 0);
    run(`OP_TEST, 4'hF, 7'h01, 1'b0, 2);
    report_and_stop;
  end
  initial begin
    #100000;
    failures++;
    report_and_stop;
  end
endmodule
`default_nettype wire
